// File: design/lrcs_pkg.sv
package lrcs_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int unsigned NUM_CHAN   = 3;
    localparam int unsigned ACC_W      = 10;
    localparam int unsigned ACC_LVL    = 6;
    localparam int unsigned CLKOUT_CH  = 1;
    localparam int unsigned PIN_W      = 4;

    // ------------------------------------------------------------
    // line rates (MHz, as printed) and the common reference
    // ------------------------------------------------------------
    localparam real E3_RATE_MHZ   = 34.368;
    localparam real DS3_RATE_MHZ  = 44.736;
    localparam real STS1_RATE_MHZ = 51.84;
    localparam real SYNTH_REF_MHZ = 12.288;

    // phase step per reference edge: 2 * rate / ref in 1/64 units
    // e3 2*2.796875, ds3 2*3.640625, sts1 2*4.21875 -- all exact
    // the sts1 step needs the tenth accumulator bit
    localparam logic [ACC_W-1:0] STEP_E3   = 10'h166;
    localparam logic [ACC_W-1:0] STEP_DS3  = 10'h1D2;
    localparam logic [ACC_W-1:0] STEP_STS1 = 10'h21C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ACC_W-1:0]    ACC_RST  = 10'h000;
    localparam logic [PIN_W-1:0]    PINS_RST = 4'h0;
    localparam logic [NUM_CHAN-1:0] LCLK_RST = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_E3   = 2'h0,
        RATE_DS3  = 2'h1,
        RATE_STS1 = 2'h2,
        RATE_NONE = 2'h3
    } lrcs_rate_t;

    typedef enum logic [1:0] {
        MODE_DIRECT = 2'h1,
        MODE_SYNTH  = 2'h2
    } lrcs_mode_t;

    // shared reference pins as sampled
    typedef struct packed {
        logic synth_mode_enable_in;
        logic e3_rate_ref_in;
        logic ds3_rate_ref_in;
        logic sts1_rate_ref_in;
    } lrcs_pins_t;

endpackage : lrcs_pkg

// File: design/lrcs_sync2.sv
`timescale 1ns/1ps
module lrcs_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // the first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : lrcs_sync2

// File: design/lrcs_clock_select.sv
`timescale 1ns/1ps
module lrcs_clock_select
    import lrcs_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // shared reference pins
    input  wire logic                  synth_mode_enable_in,
    input  wire logic                  e3_rate_ref_in,
    input  wire logic                  ds3_rate_ref_in,
    input  wire logic                  sts1_rate_ref_in,
    // clock output half of the two-way ds3 pin
    output logic                       ch1_clk_out,
    output logic                       clk_out_oe,
    // per-channel rate setting
    input  wire lrcs_rate_t            chan_rate [NUM_CHAN],
    // per-channel line clocks and mode
    output logic      [NUM_CHAN-1:0]   line_clk,
    output logic                       single_freq_synth_mode
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    lrcs_pins_t pins_raw;
    lrcs_pins_t pins_s;
    logic [PIN_W-1:0] pins_sync;

    assign pins_raw.synth_mode_enable_in = synth_mode_enable_in;
    assign pins_raw.e3_rate_ref_in       = e3_rate_ref_in;
    assign pins_raw.ds3_rate_ref_in      = ds3_rate_ref_in;
    assign pins_raw.sts1_rate_ref_in     = sts1_rate_ref_in;

    lrcs_sync2 #(
        .WIDTH    (PIN_W)
    ) u_pin_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    assign pins_s = lrcs_pins_t'(pins_sync);

    // ------------------------------------------------------------
    // mode state
    // ------------------------------------------------------------
    lrcs_mode_t mode_r;
    lrcs_mode_t mode_nxt;

    // an open enable pin reads low through its pull-down, so direct mode
    always_comb begin
        case (mode_r)
            MODE_DIRECT: mode_nxt = pins_s.synth_mode_enable_in ? MODE_SYNTH : MODE_DIRECT;
            MODE_SYNTH:  mode_nxt = pins_s.synth_mode_enable_in ? MODE_SYNTH : MODE_DIRECT;
            default:     mode_nxt = MODE_DIRECT;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= MODE_DIRECT;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    logic synth_on;
    assign synth_on               = (mode_r == MODE_SYNTH);
    assign single_freq_synth_mode = synth_on;

    // ------------------------------------------------------------
    // pin roles
    // ------------------------------------------------------------
    // the first pin doubles as the output enable in synthesis mode
    logic out_enable;
    logic common_ref;
    assign out_enable = synth_on & pins_s.e3_rate_ref_in;
    assign common_ref = synth_on & pins_s.sts1_rate_ref_in;

    // ------------------------------------------------------------
    // common reference edge detect
    // ------------------------------------------------------------
    logic ref_d_r;
    logic ref_d_nxt;
    logic ref_rise;

    always_comb begin
        ref_d_nxt = common_ref;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_d_nxt;
        end
    end

    assign ref_rise = common_ref & ~ref_d_r;

    // ------------------------------------------------------------
    // synthesiser model: one phase accumulator per channel
    // ------------------------------------------------------------
    // the step is added per reference edge, so the level bit runs at
    // the line rate relative to the reference; it is only a behavioural
    // stand-in, the real multiplier is analog and far above this clock
    logic [ACC_W-1:0] acc_r   [NUM_CHAN];
    logic [ACC_W-1:0] acc_nxt [NUM_CHAN];

    function automatic logic [ACC_W-1:0] rate_step(input lrcs_rate_t rate);
        logic [ACC_W-1:0] step;
        case (rate)
            RATE_E3:   step = STEP_E3;
            RATE_DS3:  step = STEP_DS3;
            RATE_STS1: step = STEP_STS1;
            default:   step = ACC_RST;
        endcase
        return step;
    endfunction : rate_step

    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (!synth_on) begin
                acc_nxt[c] = ACC_RST;
            end else if (ref_rise) begin
                // wraps on purpose: only the low phase bits feed the level bit
                acc_nxt[c] = ACC_W'(acc_r[c] + rate_step(chan_rate[c]));
            end else begin
                acc_nxt[c] = acc_r[c];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                acc_r[c] <= ACC_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                acc_r[c] <= acc_nxt[c];
            end
        end
    end

    // ------------------------------------------------------------
    // per-channel line clock select
    // ------------------------------------------------------------
    logic [NUM_CHAN-1:0] lclk_r;
    logic [NUM_CHAN-1:0] lclk_nxt;

    // direct mode relies on the board driving the used references and
    // grounding the rest, so an unused rate simply reads low
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (synth_on) begin
                lclk_nxt[c] = (chan_rate[c] != RATE_NONE) & acc_r[c][ACC_LVL];
            end else begin
                case (chan_rate[c])
                    RATE_E3:   lclk_nxt[c] = pins_s.e3_rate_ref_in;
                    RATE_DS3:  lclk_nxt[c] = pins_s.ds3_rate_ref_in;
                    RATE_STS1: lclk_nxt[c] = pins_s.sts1_rate_ref_in;
                    default:   lclk_nxt[c] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lclk_r <= LCLK_RST;
        end else begin
            lclk_r <= lclk_nxt;
        end
    end

    assign line_clk = lclk_r;

    // ------------------------------------------------------------
    // clock output on the ds3 pin
    // ------------------------------------------------------------
    logic cko_r;
    logic cko_nxt;
    logic cko_oe_r;
    logic cko_oe_nxt;

    // data and enable are registered side by side so the pin never carries
    // a clock level ahead of its enable; taking lclk_nxt keeps ch1_clk_out in step with line_clk
    always_comb begin
        cko_oe_nxt = out_enable;
        cko_nxt    = out_enable & lclk_nxt[CLKOUT_CH];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cko_r    <= 1'b0;
            cko_oe_r <= 1'b0;
        end else begin
            cko_r    <= cko_nxt;
            cko_oe_r <= cko_oe_nxt;
        end
    end

    assign ch1_clk_out = cko_r;
    assign clk_out_oe  = cko_oe_r;

endmodule : lrcs_clock_select

// File: test/lrcs_checker.sv
`timescale 1ns/1ps
module lrcs_checker
    import lrcs_pkg::*;
(
    // clock and reset
    input wire logic                clk,
    input wire logic                rstn,
    // watched ports
    input wire logic                synth_mode_enable_in,
    input wire logic                e3_rate_ref_in,
    input wire logic                ds3_rate_ref_in,
    input wire logic                sts1_rate_ref_in,
    input wire logic                ch1_clk_out,
    input wire logic                clk_out_oe,
    input wire lrcs_rate_t          chan_rate [NUM_CHAN],
    input wire logic [NUM_CHAN-1:0] line_clk,
    input wire logic                single_freq_synth_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_mode_follows_pin: assert property (synth_mode_enable_in [*4] |-> single_freq_synth_mode)
        else $error("mode did not follow enable pin");
    a_direct_stays_low: assert property (!synth_mode_enable_in [*4] |-> !single_freq_synth_mode)
        else $error("mode set with enable pin low");
    // e3 reference reaches channel 0 through three register stages
    a_direct_e3_path: assert property ((!single_freq_synth_mode && chan_rate[0] == RATE_E3) [*4]
        |-> line_clk[0] == $past(e3_rate_ref_in, 3))
        else $error("channel 0 does not follow e3 reference");
    a_direct_ds3_path: assert property ((!single_freq_synth_mode && chan_rate[1] == RATE_DS3) [*4]
        |-> line_clk[1] == $past(ds3_rate_ref_in, 3))
        else $error("channel 1 does not follow ds3 reference");
    a_direct_sts1_path: assert property ((!single_freq_synth_mode && chan_rate[2] == RATE_STS1) [*4]
        |-> line_clk[2] == $past(sts1_rate_ref_in, 3))
        else $error("channel 2 does not follow sts1 reference");
    a_oe_needs_mode: assert property (!single_freq_synth_mode && !$past(single_freq_synth_mode)
        |-> !clk_out_oe)
        else $error("clock output driven outside synthesis mode");
    a_oe_needs_enable: assert property (!e3_rate_ref_in [*5] |-> !clk_out_oe)
        else $error("clock output driven with enable low");
    a_oe_when_enabled: assert property ((synth_mode_enable_in && e3_rate_ref_in) [*5] |-> clk_out_oe)
        else $error("clock output not driven when enabled");
    a_out_tracks_ch1: assert property (clk_out_oe |-> ch1_clk_out == line_clk[CLKOUT_CH])
        else $error("clock output differs from channel 1 clock");
    a_out_quiet_off: assert property (!clk_out_oe |-> !ch1_clk_out)
        else $error("clock output toggles while released");
endmodule : lrcs_checker

bind lrcs_clock_select lrcs_checker u_chk (.clk(clk), .rstn(rstn),
    .synth_mode_enable_in(synth_mode_enable_in), .e3_rate_ref_in(e3_rate_ref_in),
    .ds3_rate_ref_in(ds3_rate_ref_in), .sts1_rate_ref_in(sts1_rate_ref_in), .ch1_clk_out(ch1_clk_out),
    .clk_out_oe(clk_out_oe), .chan_rate(chan_rate), .line_clk(line_clk),
    .single_freq_synth_mode(single_freq_synth_mode));

// File: test/lrcs_board_clocks.sv
`timescale 1ns/1ps
module lrcs_board_clocks (
    // board state
    input  wire logic       clk,
    input  wire logic       synth,
    input  wire logic       run,
    input  wire logic [2:0] used,
    // reference pins
    output logic            e3_ref,
    output logic            ds3_ref,
    output logic            sts1_ref,
    output int              n_edge
);
    int   ph = 0;
    logic nxt;
    initial begin
        e3_ref = 1'b0;
        ds3_ref = 1'b0;
        sts1_ref = 1'b0;
        n_edge = 0;
    end
    always @(negedge clk) begin
        nxt = synth ? run && ph[2] : used[2] && ph[0];
        if (synth && nxt && !sts1_ref) n_edge <= n_edge + 1;
        sts1_ref <= nxt;
        e3_ref <= !synth && used[0] && ph[1];
        // released pin must not hold its last level
        ds3_ref <= synth ? !ds3_ref : used[1] && ph % 6 < 3;
        ph <= ph + 1;
    end
endmodule : lrcs_board_clocks

// File: test/lrcs_clock_select_bench.sv
`timescale 1ns/1ps
module lrcs_clock_select_bench;
    import lrcs_pkg::*;
    typedef struct packed { lrcs_rate_t rate; logic [7:0] toggles; } lrcs_row_t;
    localparam lrcs_row_t ROWS [4] = '{'{RATE_E3, 8'h18}, '{RATE_DS3, 8'h10}, '{RATE_STS1, 8'h30},
                                       '{RATE_NONE, 8'h00}};
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                mode_pin = 1'b0;
    logic                clk_en = 1'b0;
    logic                run = 1'b0;
    logic [2:0]          used = 3'h0;
    lrcs_rate_t          rate [NUM_CHAN] = '{RATE_E3, RATE_E3, RATE_E3};
    logic                e3_ref, ds3_ref, sts1_ref, out_o, out_oe, mode;
    logic [NUM_CHAN-1:0] line, prev;
    logic [ACC_W-1:0]    acc [NUM_CHAN];
    int                  n_edge, cnt [NUM_CHAN];
    int                  n_mismatch = 0;
    int                  samples_checked = 0;
    wire                 e3_pin = mode_pin ? clk_en : e3_ref;
    wire                 ds3_pin = out_oe ? out_o : ds3_ref;
    always #20 clk = ~clk;

    lrcs_board_clocks u_board (.clk(clk), .synth(mode_pin), .run(run), .used(used), .e3_ref(e3_ref),
        .ds3_ref(ds3_ref), .sts1_ref(sts1_ref), .n_edge(n_edge));
    lrcs_clock_select DUT (.clk(clk), .rstn(rstn), .synth_mode_enable_in(mode_pin), .e3_rate_ref_in(e3_pin),
        .ds3_rate_ref_in(ds3_pin), .sts1_rate_ref_in(sts1_ref), .ch1_clk_out(out_o), .clk_out_oe(out_oe),
        .chan_rate(rate), .line_clk(line), .single_freq_synth_mode(mode));

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // bounded wait for the next common reference edge
    task automatic next_edge;
        int last;
        last = n_edge;
        for (int i = 0; i < 40 && n_edge == last; i++) @(negedge clk);
        if (n_edge == last) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : next_edge

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        check(mode, 1'b0);
        check(line, 3'h0);
        rstn = 1'b1;
        $display("reset test done");
        foreach (ROWS[r]) begin
            used = 3'h1 << ROWS[r].rate;
            rate = '{ROWS[r].rate, ROWS[r].rate, ROWS[r].rate};
            repeat (8) @(negedge clk);
            cnt = '{0, 0, 0};
            prev = line;
            for (int i = 0; i < 48; i++) begin
                @(negedge clk);
                foreach (cnt[c]) cnt[c] += (line[c] !== prev[c]);
                prev = line;
            end
            foreach (cnt[c]) check(cnt[c][8:0], {1'b0, ROWS[r].toggles});
            check(out_oe, 1'b0);
            $display("direct rate %0d done", r);
        end
        rate = '{RATE_E3, RATE_DS3, RATE_STS1};
        used = 3'h0;
        mode_pin = 1'b1;
        clk_en = 1'b1;
        repeat (8) @(negedge clk);
        check(mode, 1'b1);
        check(out_oe, 1'b1);
        acc = '{ACC_RST, ACC_RST, ACC_RST};
        run = 1'b1;
        for (int k = 0; k < 12; k++) begin
            next_edge();
            foreach (acc[c]) acc[c] += rate[c] == RATE_E3 ? STEP_E3 : rate[c] == RATE_DS3 ? STEP_DS3 : STEP_STS1;
            repeat (6) @(negedge clk);
            foreach (acc[c]) check(line[c], acc[c][6]);
            check(out_o, acc[1][6]);
            // channel 1 retuned mid-run so the output must follow the new rate
            if (k == 5) rate[1] = RATE_STS1;
        end
        $display("synthesis test done");
        clk_en = 1'b0;
        repeat (6) @(negedge clk);
        check(out_oe, 1'b0);
        check(out_o, 1'b0);
        clk_en = 1'b1;
        repeat (6) @(negedge clk);
        check(out_oe, 1'b1);
        mode_pin = 1'b0;
        run = 1'b0;
        repeat (6) @(negedge clk);
        check(mode, 1'b0);
        check(out_oe, 1'b0);
        $display("enable test done");
        give_verdict();
    end
endmodule : lrcs_clock_select_bench
